// *** pkg/dsps_params.svh ***
// Notes on behaviour
// - Four phases cycle in fixed order.
// - System zero keeps the input switch open.
// - System zero closes zero-loop, charge, feedback switches.
// - Input integration closes only input switches.
// - Latch comparator sign at end of integration.
// - Reference phase uses sign-selected reference switch.
// - Count reference clocks until zero crossing.
// - Integrator zero closes zero, feedback; 200 clocks.
// - Overrange stretches integrator zero to 6200.
// - System zero lasts at least 10001 clocks.
// - Running continuously, cycle repeats every 40002 when crossing by count 19800.
// - Reference beyond 20000 clocks flags overrange.
// - Busy from integration start until crossing or overrange limit.
`ifndef DSPS_PARAMS_SVH
`define DSPS_PARAMS_SVH

`define DSPS_SZ_LEN 10001
`define DSPS_INT_LEN 10000
`define DSPS_OVR_LIMIT 20000
`define DSPS_IZ_LEN 200
`define DSPS_OVR_IZ_LEN 6200
`define DSPS_PERIOD 40002

`define DSPS_ADDR_CTRL 8'h00
`define DSPS_ADDR_STATUS 8'h04
`define DSPS_ADDR_RESULT 8'h08
`define DSPS_ADDR_IRQ_STAT 8'h0c
`define DSPS_ADDR_IRQ_MASK 8'h10

`define DSPS_CTRL_RUN 0
`define DSPS_CTRL_START 1
`define DSPS_CTRL_RUN_RST 1'h1

`define DSPS_IRQ_DONE 0
`define DSPS_IRQ_OVR 1

`define DSPS_CNT_MAX 16'hffff

`endif

// *** pkg/dsps_pkg.sv ***
package dsps_pkg;

	typedef enum logic [1:0] {
		PH_SZ = 2'h0,
		PH_INT = 2'h1,
		PH_REF = 2'h3,
		PH_IZ = 2'h2
	} dsps_phase_t;

	typedef struct packed {
		logic input_connect_switch;
		logic ref_positive_switch;
		logic ref_negative_switch;
		logic zero_loop_switch;
		logic ref_charge_switch;
		logic integ_feedback_switch;
		logic integ_zero_switch;
	} dsps_sw_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} dsps_bus_req_t;

	typedef struct packed {
		logic [15:0] cnt;
	} dsps_cnt_st_t;

	typedef struct packed {
		dsps_phase_t phase;
		dsps_sw_t sw;
		logic busy;
		logic pol;
		logic ovr;
		logic [15:0] result;
		logic [15:0] slack;
		logic run;
		logic start_pend;
		logic [1:0] irq_stat;
		logic [1:0] irq_mask;
		logic [31:0] rdata;
	} dsps_st_t;

endpackage

// *** src/dsps_phase_counter.sv ***
`timescale 1ns/100ps
`include "dsps_params.svh"

module dsps_phase_counter (
	input wire logic clk,
	input wire logic reset,
	input wire logic clear,
	output logic [15:0] count
);

	dsps_pkg::dsps_cnt_st_t s;
	dsps_pkg::dsps_cnt_st_t next_s;

	// Saturates so an indefinite hold cannot wrap back below a limit
	always_comb begin
		next_s = s;
		if (clear) begin
			next_s.cnt = 16'h0000;
		end else if (s.cnt != `DSPS_CNT_MAX) begin
			next_s.cnt = s.cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign count = s.cnt;

endmodule

// *** src/dsps_sequencer.sv ***
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps
`include "dsps_params.svh"

module dsps_sequencer #(
	parameter int unsigned SZ_LEN = `DSPS_SZ_LEN,
	parameter int unsigned INT_LEN = `DSPS_INT_LEN,
	parameter int unsigned OVR_LIMIT = `DSPS_OVR_LIMIT,
	parameter int unsigned OVR_IZ_LEN = `DSPS_OVR_IZ_LEN,
	parameter int unsigned PERIOD = `DSPS_PERIOD
) (
	input wire logic clk,
	input wire logic reset,
	input wire dsps_pkg::dsps_bus_req_t bus,
	output logic [31:0] rdata,
	input wire logic comp_out,
	output dsps_pkg::dsps_sw_t switches,
	output logic busy,
	output logic polarity,
	output logic overrange,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////
	// Constants

	localparam int unsigned IZ_LEN = `DSPS_IZ_LEN;
	localparam logic [15:0] SZ_E = 16'(SZ_LEN - 1);
	localparam logic [15:0] INT_E = 16'(INT_LEN - 1);
	localparam logic [15:0] OVR_E = 16'(OVR_LIMIT);
	localparam logic [15:0] IZ_E = 16'(IZ_LEN - 1);
	localparam logic [15:0] OIZ_E = 16'(OVR_IZ_LEN - 1);
	// Reference count up to which the next system zero is padded
	localparam logic [15:0] SLACK_LIM =
		16'(PERIOD - SZ_LEN - INT_LEN - IZ_LEN - 1);

	////////////////////////////////////////////////////////////////////////
	// Switch decode per phase

	function automatic dsps_pkg::dsps_sw_t sw_of(
		input dsps_pkg::dsps_phase_t ph,
		input logic pos
	);
		dsps_pkg::dsps_sw_t w;
		w = '0;
		case (ph)
			dsps_pkg::PH_SZ: begin
				w.zero_loop_switch = 1'b1;
				w.ref_charge_switch = 1'b1;
				w.integ_feedback_switch = 1'b1;
			end
			dsps_pkg::PH_INT: begin
				w.input_connect_switch = 1'b1;
			end
			dsps_pkg::PH_REF: begin
				w.integ_feedback_switch = 1'b1;
				w.ref_positive_switch = pos;
				w.ref_negative_switch = ~pos;
			end
			default: begin
				w.integ_zero_switch = 1'b1;
				w.integ_feedback_switch = 1'b1;
			end
		endcase
		return w;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State

	dsps_pkg::dsps_st_t s;
	dsps_pkg::dsps_st_t next_s;
	logic [15:0] cnt;
	logic cnt_clear;

	dsps_phase_counter u_cnt (
		.clk(clk),
		.reset(reset),
		.clear(cnt_clear),
		.count(cnt)
	);

	assign cnt_clear = (next_s.phase != s.phase);

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic [15:0] sz_end;
		logic [15:0] iz_end;
		logic [1:0] ev;
		sz_end = SZ_E + s.slack;
		iz_end = s.ovr ? OIZ_E : IZ_E;
		ev = 2'h0;
		next_s = s;

		case (s.phase)
			dsps_pkg::PH_SZ: begin
				// Waits here while held; slack keeps the period fixed
				if (cnt >= sz_end && (s.run || s.start_pend)) begin
					next_s.phase = dsps_pkg::PH_INT;
					next_s.start_pend = 1'b0;
				end
			end
			dsps_pkg::PH_INT: begin
				if (cnt == INT_E) begin
					next_s.phase = dsps_pkg::PH_REF;
					next_s.pol = comp_out;
					next_s.ovr = 1'b0;
				end
			end
			dsps_pkg::PH_REF: begin
				if (comp_out != s.pol) begin
					next_s.phase = dsps_pkg::PH_IZ;
					next_s.result = cnt;
					ev[`DSPS_IRQ_DONE] = 1'b1;
					if (cnt <= SLACK_LIM) begin
						next_s.slack = SLACK_LIM - cnt;
					end else begin
						next_s.slack = 16'h0000;
					end
				end else if (cnt == OVR_E) begin
					next_s.phase = dsps_pkg::PH_IZ;
					next_s.ovr = 1'b1;
					next_s.result = OVR_E;
					next_s.slack = 16'h0000;
					ev[`DSPS_IRQ_DONE] = 1'b1;
					ev[`DSPS_IRQ_OVR] = 1'b1;
				end
			end
			default: begin
				if (cnt == iz_end) begin
					next_s.phase = dsps_pkg::PH_SZ;
				end
			end
		endcase

		next_s.sw = sw_of(next_s.phase, next_s.pol);
		next_s.busy = (next_s.phase == dsps_pkg::PH_INT) ||
			(next_s.phase == dsps_pkg::PH_REF);

		if (bus.wr) begin
			if (bus.addr == `DSPS_ADDR_CTRL) begin
				next_s.run = bus.wdata[`DSPS_CTRL_RUN];
				if (bus.wdata[`DSPS_CTRL_START]) begin
					next_s.start_pend = 1'b1;
				end
			end else if (bus.addr == `DSPS_ADDR_IRQ_STAT) begin
				next_s.irq_stat = s.irq_stat & ~bus.wdata[1:0];
			end else if (bus.addr == `DSPS_ADDR_IRQ_MASK) begin
				next_s.irq_mask = bus.wdata[1:0];
			end
		end
		// Events applied after the clear so a same-cycle set survives
		next_s.irq_stat = next_s.irq_stat | ev;

		next_s.rdata = 32'h0000_0000;
		if (bus.rd) begin
			if (bus.addr == `DSPS_ADDR_CTRL) begin
				next_s.rdata = {30'h0, s.start_pend, s.run};
			end else if (bus.addr == `DSPS_ADDR_STATUS) begin
				next_s.rdata = {27'h0, s.phase, s.busy, s.ovr, s.pol};
			end else if (bus.addr == `DSPS_ADDR_RESULT) begin
				next_s.rdata = {16'h0, s.result};
			end else if (bus.addr == `DSPS_ADDR_IRQ_STAT) begin
				next_s.rdata = {30'h0, s.irq_stat};
			end else if (bus.addr == `DSPS_ADDR_IRQ_MASK) begin
				next_s.rdata = {30'h0, s.irq_mask};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk) begin
		if (reset) begin
			s <= '0;
			s.sw <= sw_of(dsps_pkg::PH_SZ, 1'b0);
			s.run <= `DSPS_CTRL_RUN_RST;
		end else begin
			s <= next_s;
		end
	end

	assign rdata = s.rdata;
	assign switches = s.sw;
	assign busy = s.busy;
	assign polarity = s.pol;
	assign overrange = s.ovr;
	assign irq = |(s.irq_stat & s.irq_mask);

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	AST_ORDER: assert property (
		s.phase != $past(s.phase) |->
		(s.phase == dsps_pkg::PH_INT &&
			$past(s.phase) == dsps_pkg::PH_SZ) ||
		(s.phase == dsps_pkg::PH_REF &&
			$past(s.phase) == dsps_pkg::PH_INT) ||
		(s.phase == dsps_pkg::PH_IZ &&
			$past(s.phase) == dsps_pkg::PH_REF) ||
		(s.phase == dsps_pkg::PH_SZ &&
			$past(s.phase) == dsps_pkg::PH_IZ)
	) else $error("phase order broken");

	AST_SZ_SW: assert property (
		s.phase == dsps_pkg::PH_SZ |->
		!switches.input_connect_switch && switches.zero_loop_switch &&
		switches.ref_charge_switch && switches.integ_feedback_switch
	) else $error("system zero switch set wrong");

	AST_INT_SW: assert property (
		s.phase == dsps_pkg::PH_INT |->
		switches == dsps_pkg::dsps_sw_t'(7'h40)
	) else $error("integration switch set wrong");

	AST_REF_SW: assert property (
		s.phase == dsps_pkg::PH_REF |->
		switches.ref_positive_switch == polarity &&
		switches.ref_negative_switch == !polarity &&
		switches.integ_feedback_switch && !switches.input_connect_switch
	) else $error("reference switch set wrong");

	AST_POL: assert property (
		s.phase == dsps_pkg::PH_INT && cnt == INT_E |=>
		s.phase == dsps_pkg::PH_REF && polarity == $past(comp_out)
	) else $error("polarity not latched at integration end");

	AST_INT_LEN: assert property (
		s.phase == dsps_pkg::PH_INT && cnt != INT_E |=>
		s.phase == dsps_pkg::PH_INT
	) else $error("integration ended early");

	AST_READING: assert property (
		s.phase == dsps_pkg::PH_REF && comp_out != polarity |=>
		s.phase == dsps_pkg::PH_IZ && s.result == $past(cnt) &&
		!overrange
	) else $error("reading not captured at crossing");

	AST_OVR: assert property (
		s.phase == dsps_pkg::PH_REF && comp_out == polarity &&
		cnt == OVR_E |=> overrange && s.phase == dsps_pkg::PH_IZ
	) else $error("overrange not flagged");

	AST_IZ_LEN: assert property (
		s.phase == dsps_pkg::PH_IZ ##1 s.phase == dsps_pkg::PH_SZ |->
		$past(cnt) == ($past(overrange) ? OIZ_E : IZ_E)
	) else $error("integrator zero length wrong");

	AST_OVR_IZ: assert property (
		s.phase == dsps_pkg::PH_IZ && overrange && cnt < OIZ_E |=>
		s.phase == dsps_pkg::PH_IZ
	) else $error("overrange zero phase cut short");

	AST_SZ_LEN: assert property (
		s.phase == dsps_pkg::PH_SZ && cnt < SZ_E |=>
		s.phase == dsps_pkg::PH_SZ
	) else $error("system zero too short");

	AST_PERIOD: assert property (
		s.phase == dsps_pkg::PH_SZ && s.run && cnt == SZ_E + s.slack
		|=> s.phase == dsps_pkg::PH_INT
	) else $error("continuous cycle not restarted");

	AST_BUSY: assert property (
		busy == (s.phase == dsps_pkg::PH_INT ||
			s.phase == dsps_pkg::PH_REF)
	) else $error("busy does not track conversion");

	////////////////////////////////////////////////////////////////////////
	// Outputs that move only at their own phase boundary

	AST_SW_STAND: assert property (
		$stable(s.phase) |-> $stable(switches)
	) else $error("switch set changed inside a phase");

	AST_IZ_SW: assert property (
		s.phase == dsps_pkg::PH_IZ |->
		switches == dsps_pkg::dsps_sw_t'(7'h03)
	) else $error("integrator zero switch set wrong");

	AST_POL_HOLD: assert property (
		$changed(polarity) |->
		s.phase == dsps_pkg::PH_REF &&
		$past(s.phase) == dsps_pkg::PH_INT
	) else $error("polarity moved outside integration end");

	AST_OVR_RISE: assert property (
		$rose(overrange) |->
		s.phase == dsps_pkg::PH_IZ &&
		$past(s.phase) == dsps_pkg::PH_REF
	) else $error("overrange set outside reference end");

	AST_OVR_FALL: assert property (
		$fell(overrange) |->
		s.phase == dsps_pkg::PH_REF &&
		$past(s.phase) == dsps_pkg::PH_INT
	) else $error("overrange cleared outside reference start");

	AST_OVR_CLR: assert property (
		s.phase == dsps_pkg::PH_INT && cnt == INT_E |=> !overrange
	) else $error("overrange kept into reference phase");

	AST_REF_LIMIT: assert property (
		s.phase == dsps_pkg::PH_REF |-> cnt <= OVR_E
	) else $error("reference phase ran past its limit");

	AST_RESULT_HOLD: assert property (
		$changed(s.result) |->
		s.phase == dsps_pkg::PH_IZ &&
		$past(s.phase) == dsps_pkg::PH_REF
	) else $error("reading changed outside reference end");

	AST_HOLD: assert property (
		s.phase == dsps_pkg::PH_SZ && !s.run && !s.start_pend |=>
		s.phase == dsps_pkg::PH_SZ
	) else $error("conversion started while held");

	AST_START: assert property (
		s.phase == dsps_pkg::PH_SZ && s.start_pend &&
		cnt >= SZ_E + s.slack |=> s.phase == dsps_pkg::PH_INT
	) else $error("single conversion not started");

	////////////////////////////////////////////////////////////////////////
	// Register port and interrupt flags

	AST_RDATA_IDLE: assert property (
		!$past(bus.rd) |-> rdata == 32'h0000_0000
	) else $error("read data not zero outside read cycle");

	AST_DONE_SET: assert property (
		s.phase == dsps_pkg::PH_REF ##1 s.phase == dsps_pkg::PH_IZ |->
		s.irq_stat[`DSPS_IRQ_DONE]
	) else $error("done flag not set at conversion end");

	AST_OVR_SET: assert property (
		$rose(overrange) |-> s.irq_stat[`DSPS_IRQ_OVR]
	) else $error("overrange flag not set");

	// Outside reference phase no done event can compete with the clear
	AST_DONE_CLR: assert property (
		bus.wr && bus.addr == `DSPS_ADDR_IRQ_STAT &&
		bus.wdata[`DSPS_IRQ_DONE] && s.phase != dsps_pkg::PH_REF |=>
		!s.irq_stat[`DSPS_IRQ_DONE]
	) else $error("done flag not cleared by write");

	AST_MASK_WR: assert property (
		bus.wr && bus.addr == `DSPS_ADDR_IRQ_MASK |=>
		s.irq_mask == $past(bus.wdata[1:0])
	) else $error("mask write not applied");

	COV_OVR: cover property (s.phase == dsps_pkg::PH_IZ && overrange &&
		cnt == OIZ_E);
	COV_NEG: cover property (s.phase == dsps_pkg::PH_REF && !polarity
		##1 s.phase == dsps_pkg::PH_IZ);
	COV_HOLD: cover property (s.phase == dsps_pkg::PH_SZ && !s.run &&
		cnt > SZ_E);
	COV_IRQ: cover property (irq);

endmodule

// *** bench/dsps_analog_model.sv ***
`timescale 1ns/100ps
module dsps_analog_model (
	input wire logic clk,
	input wire dsps_pkg::dsps_sw_t sw,
	input wire integer level,
	output logic comp_out
);
	////////////////////////////////////////
	// Integrator: input slope per clock, unit reference slope, zeroing
	int integ;

	always_ff @(posedge clk) begin
		if (sw.input_connect_switch)
			integ <= integ + level;
		else if (sw.ref_positive_switch)
			integ <= integ - 1;
		else if (sw.ref_negative_switch)
			integ <= integ + 1;
		else if (sw.integ_zero_switch || sw.zero_loop_switch)
			integ <= 0;
	end

	// Comparator high while the integrator sits on the positive side
	assign comp_out = integ > 0;
endmodule

// *** bench/tb.sv ***
`timescale 1ns/100ps
module tb;
	typedef struct {
		int lvl;
		logic [31:0] pol;
		logic [31:0] res;
		logic [31:0] ovr;
	} dsps_row_t;
	dsps_row_t rows[6] = '{'{1, 1, 16, 0}, '{2, 1, 32, 0}, '{-1, 0, 17, 0},
		'{-2, 0, 33, 0}, '{0, 0, 1, 0}, '{3, 1, 40, 1}};
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic comp_out;
	dsps_pkg::dsps_bus_req_t bus = '0;
	dsps_pkg::dsps_sw_t switches;
	logic [31:0] rdata;
	logic [31:0] d;
	logic [6:0] prev;
	logic busy, polarity, overrange, irq;
	int level = 0;
	int err_total = 0;
	int total_checks = 0;
	int cyc = 0;
	int len = 0;
	int sz_exp = 20;
	int t_int = 0;
	int t0;

	dsps_sequencer #(.SZ_LEN(20), .INT_LEN(16), .OVR_LIMIT(40),
		.OVR_IZ_LEN(50), .PERIOD(300)) i_dsps_sequencer (.clk(clk),
		.reset(reset), .bus(bus), .rdata(rdata), .comp_out(comp_out),
		.switches(switches), .busy(busy), .polarity(polarity),
		.overrange(overrange), .irq(irq));
	dsps_analog_model i_dsps_analog_model (.clk(clk), .sw(switches),
		.level(level), .comp_out(comp_out));

	initial forever #2 clk = ~clk;

	////////////////////////////////////////
	task automatic chk(string w, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", w, e, g);
		end
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] v);
		@(posedge clk);
		bus.addr <= a;
		bus.wdata <= v;
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask

	task automatic wait_busy(logic v);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (busy !== v && n < 400);
		chk("busy_wait", 32'(v), 32'(busy));
	endtask

	task automatic give_verdict();
		$display("checks %0d, errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	////////////////////////////////////////
	// Phase monitor: order, switch sets, lengths of integration and integrator zero, and system zero length or the period
	always @(negedge clk) begin
		cyc++;
		if (reset) begin
			prev = 7'h0e;
			len = 0;
			sz_exp = 20;
			t_int = 0;
		end else begin
			chk("busy", 32'(switches[6] | switches[5] | switches[4]),
				32'(busy));
			if (switches === prev) begin
				len++;
			end else begin
				case (prev)
				7'h0e: begin
					chk("sz_next", 32'h40, 32'(switches));
					if (sz_exp != 0)
						chk("sz_len", sz_exp, len);
					else if (t_int != 0)
						chk("period", 300, cyc - t_int);
					t_int = cyc;
				end
				7'h40: begin
					chk("ref_sw", polarity ? 32'h22 : 32'h12,
						32'(switches));
					chk("int_len", 16, len);
				end
				7'h22, 7'h12: chk("ref_next", 32'h03, 32'(switches));
				default: begin
					chk("iz_next", 32'h0e, 32'(switches));
					chk("iz_len", overrange ? 50 : 200, len);
					sz_exp = overrange ? 20 : 0;
				end
				endcase
				prev = switches;
				len = 1;
			end
		end
	end

	initial begin
		#80000;
		err_total++;
		give_verdict();
	end

	////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		wr(8'h10, 32'h3);
		foreach (rows[i]) begin
			level = rows[i].lvl;
			wait_busy(1'b1);
			wait_busy(1'b0);
			chk("polarity", rows[i].pol, 32'(polarity));
			chk("overrange", rows[i].ovr, 32'(overrange));
			rd(8'h08, d);
			chk("result", rows[i].res, d);
			rd(8'h0c, d);
			chk("irq_stat", (rows[i].ovr << 1) | 32'h1, d);
			chk("irq", 32'h1, 32'(irq));
			wr(8'h0c, 32'h3);
			@(negedge clk);
			chk("irq_clr", 32'h0, 32'(irq));
		end
		// Reset in mid-run, during the overrange zero phase
		@(posedge clk);
		reset <= 1'b1;
		repeat (3) @(negedge clk);
		chk("rst_sw", 32'h0e, 32'(switches));
		chk("rst_out", 32'h0, 32'({busy, polarity, overrange, irq}));
		@(posedge clk);
		reset <= 1'b0;
		rd(8'h00, d);
		chk("ctrl", 32'h1, d);
		rd(8'h04, d);
		chk("status", 32'h0, d);
		rd(8'h10, d);
		chk("mask", 32'h0, d);
		rd(8'h20, d);
		chk("unmapped", 32'h0, d);
		// Hold: the running conversion completes, then none starts
		level = 1;
		wait_busy(1'b1);
		wr(8'h00, 32'h0);
		wait_busy(1'b0);
		t0 = t_int;
		repeat (400) @(negedge clk);
		chk("hold", t0, t_int);
		chk("hold_sw", 32'h0e, 32'(switches));
		t_int = 0;
		wr(8'h00, 32'h2);
		wait_busy(1'b1);
		wait_busy(1'b0);
		chk("irq_masked", 32'h0, 32'(irq));
		rd(8'h0c, d);
		chk("single_stat", 32'h1, d);
		wr(8'h10, 32'h1);
		@(negedge clk);
		chk("irq_unmask", 32'h1, 32'(irq));
		wr(8'h0c, 32'h1);
		@(negedge clk);
		chk("irq_clear", 32'h0, 32'(irq));
		give_verdict();
	end
endmodule
